// ---- verilog/ocs_pkg.sv ----
// Constants, types and register map of the system clock source switcher.
// Assumes a 100 MHz reference clock and oscillator levels sampled on it.
package ocs_pkg;

    // Register offsets, byte addresses of aligned words
    localparam logic [7:0] OSC_CTRL_OFF   = 8'h00;
    localparam logic [7:0] T1_CTRL_OFF    = 8'h04;
    localparam logic [7:0] IRQ_STS_OFF    = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFF   = 8'h0C;
    localparam logic [7:0] SW_STS_OFF     = 8'h10;

    // Field positions
    localparam int FREQ_SEL_LSB  = 4;
    localparam int STARTUP_BIT   = 3;
    localparam int STABLE_BIT    = 2;
    localparam int SRC_SEL_LSB   = 0;
    localparam int T1_EN_BIT     = 0;
    localparam int T1_ACTIVE_BIT = 6;
    localparam int BUSY_BIT      = 0;
    localparam int STAB_RUN_BIT  = 1;
    localparam int IRQ_DONE      = 0;
    localparam int IRQ_STABLE    = 1;
    localparam int IRQ_T1_ACTIVE = 2;
    localparam int IRQ_W         = 3;

    // Select encodings
    localparam int          SRC_T1_BIT   = 0;
    localparam int          SRC_INT_BIT  = 1;
    localparam logic [1:0]  SRC_PRIMARY  = 2'h0;
    localparam logic [1:0]  SRC_TIMER1   = 2'h1;
    localparam logic [2:0]  FREQ_LF      = 3'h0;
    localparam logic [2:0]  FREQ_HF_FULL = 3'h7;

    // Reset values
    localparam logic [2:0]        FREQ_RST = 3'h0;
    localparam logic [1:0]        SRC_RST  = 2'h0;
    localparam logic [IRQ_W-1:0]  MASK_RST = 3'h0;

    // Postscaler and edge counting
    localparam int          PSC_W      = 7;
    localparam int          PSC_TOP    = 6;
    localparam logic [3:0]  EDGE_LAST  = 4'h7;
    localparam logic [3:0]  EDGE_ZERO  = 4'h0;

    // Settle delay after going from the slow RC clock to a faster internal setting
    localparam int CLK_PERIOD_NS = 10;
    localparam int STAB_TIME_NS  = 4000000;
    localparam int STAB_CYCLES   = STAB_TIME_NS / CLK_PERIOD_NS;
    localparam int STAB_W        = 19;

    typedef struct packed {
        logic primary;
        logic t1_xtal;
        logic lf_rc;
        logic hf_rc;
    } ocs_osc_in_t;

    typedef struct packed {
        logic [1:0] src;
        logic [2:0] freq;
    } ocs_sel_t;

    typedef enum logic [1:0] {SW_IDLE, SW_GATE, SW_COUNT} ocs_sw_state_t;

endpackage : ocs_pkg

// ---- verilog/ocs_top.sv ----
// System clock source switcher with APB register access and interrupt.
// Assumes oscillator levels and APB signals are synchronous to ref_clk.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
module ocs_top #(
    parameter int STAB_CYCLES_P = ocs_pkg::STAB_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire ocs_pkg::ocs_osc_in_t osc_in,
    output logic                      clock_output,
    output logic                      first_phase_hold,
    output logic                      primary_osc_enable,
    output logic                      timer1_osc_enable,
    output logic                      secondary_run_mode,
    output logic                      irq
);
    import ocs_pkg::*;

    // Control registers
    logic [2:0]        int_osc_freq_select_ff;
    logic [1:0]        sysclk_source_select_ff;
    logic              timer1_osc_enable_ff;
    logic [IRQ_W-1:0]  irq_mask_ff;
    logic [IRQ_W-1:0]  irq_sts_ff;
    logic              irq_ff;
    // APB answer
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic [31:0]       nxt_prdata;
    logic              nxt_pslverr;
    // Switch sequencer
    ocs_sw_state_t     state_ff;
    ocs_sel_t          act_ff;
    ocs_sel_t          tgt_ff;
    ocs_sel_t          nxt_tgt;
    logic [3:0]        edge_cnt_ff;
    logic              gate_low_ff;
    // Settle delay
    logic              int_freq_stable_flag_ff;
    logic              stab_run_ff;
    logic [STAB_W-1:0] stab_cnt_ff;
    // Status outputs
    logic              osc_startup_status_ff;
    logic              timer1_sysclk_running_flag_ff;
    logic              first_phase_hold_ff;
    logic              primary_osc_enable_ff;
    logic              secondary_run_mode_ff;
    logic              clock_output_ff;
    // Edge tracking
    logic [PSC_W-1:0]  psc_ff;
    logic              hf_prev_ff;
    logic              old_prev_ff;
    logic              new_prev_ff;
    logic              old_lvl;
    logic              new_lvl;
    logic              old_fall;
    logic              new_fall;
    // Decodes and events
    logic              apb_wr;
    logic              need_switch;
    logic              sw_done;
    logic              from_lf_up;
    logic              stab_end;
    logic [IRQ_W-1:0]  ev_vec;

    // Level of the clock that a select pair names
    function automatic logic clk_level(input ocs_sel_t sel, input ocs_osc_in_t osc,
                                       input logic [PSC_W-1:0] psc);
        logic lvl;
        lvl = osc.primary;
        if (sel.src[SRC_INT_BIT]) begin
            if (sel.freq == FREQ_LF) begin
                lvl = osc.lf_rc;
            end else if (sel.freq == FREQ_HF_FULL) begin
                lvl = osc.hf_rc;
            end else begin
                lvl = psc[PSC_TOP - int'(sel.freq)];
            end
        end else if (sel.src[SRC_T1_BIT]) begin
            lvl = osc.t1_xtal;
        end
        return lvl;
    endfunction : clk_level

    // True when the pair selects the slow RC clock
    function automatic logic is_lf(input ocs_sel_t sel);
        return sel.src[SRC_INT_BIT] && (sel.freq == FREQ_LF);
    endfunction : is_lf

    // True when the pair selects the timer crystal
    function automatic logic is_t1(input ocs_sel_t sel);
        return !sel.src[SRC_INT_BIT] && sel.src[SRC_T1_BIT];
    endfunction : is_t1

    // Timer crystal request falls back when that oscillator is off
    function automatic logic [1:0] resolve_src(input logic [1:0] req, input logic t1_en);
        logic [1:0] res;
        res = req;
        if (!t1_en && req[SRC_T1_BIT]) begin
            res = {req[SRC_INT_BIT], 1'b0};
        end
        return res;
    endfunction : resolve_src

    // Bus and sequencer decodes
    assign apb_wr      = psel && penable && pready_ff && pwrite;
    assign nxt_tgt     = '{src: sysclk_source_select_ff, freq: int_osc_freq_select_ff};
    assign need_switch = (nxt_tgt.src != act_ff.src) ||
                         (nxt_tgt.src[SRC_INT_BIT] && (nxt_tgt.freq != act_ff.freq));
    assign old_lvl     = clk_level(act_ff, osc_in, psc_ff);
    assign new_lvl     = clk_level(tgt_ff, osc_in, psc_ff);
    assign old_fall    = old_prev_ff && !old_lvl;
    assign new_fall    = new_prev_ff && !new_lvl;
    assign sw_done     = (state_ff == SW_COUNT) && new_fall && (edge_cnt_ff == EDGE_LAST);
    assign from_lf_up  = is_lf(act_ff) && tgt_ff.src[SRC_INT_BIT] && (tgt_ff.freq != FREQ_LF);
    assign stab_end    = stab_run_ff && (stab_cnt_ff == STAB_W'(STAB_CYCLES_P - 1));
    assign ev_vec      = {sw_done && is_t1(tgt_ff), stab_end, sw_done};

    // Software control fields; the frequency field is taken whatever runs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_osc_freq_select_ff  <= FREQ_RST;
            sysclk_source_select_ff <= SRC_RST;
            timer1_osc_enable_ff    <= 1'b0;
            irq_mask_ff             <= MASK_RST;
        end else if (clk_en && apb_wr) begin
            if (paddr == OSC_CTRL_OFF) begin
                int_osc_freq_select_ff  <= pwdata[FREQ_SEL_LSB +: 3];
                sysclk_source_select_ff <= resolve_src(pwdata[SRC_SEL_LSB +: 2],
                                                       timer1_osc_enable_ff);
            end
            if (paddr == T1_CTRL_OFF) begin
                timer1_osc_enable_ff <= pwdata[T1_EN_BIT];
            end
            if (paddr == IRQ_MASK_OFF) begin
                irq_mask_ff <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Read mux, sampled in the setup cycle
    always_comb begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        case (paddr)
            OSC_CTRL_OFF: begin
                nxt_prdata[FREQ_SEL_LSB +: 3] = int_osc_freq_select_ff;
                nxt_prdata[STARTUP_BIT]       = osc_startup_status_ff;
                nxt_prdata[STABLE_BIT]        = int_freq_stable_flag_ff;
                nxt_prdata[SRC_SEL_LSB +: 2]  = sysclk_source_select_ff;
            end
            T1_CTRL_OFF: begin
                nxt_prdata[T1_EN_BIT]     = timer1_osc_enable_ff;
                nxt_prdata[T1_ACTIVE_BIT] = timer1_sysclk_running_flag_ff;
            end
            IRQ_STS_OFF: begin
                nxt_prdata[IRQ_W-1:0] = irq_sts_ff;
            end
            IRQ_MASK_OFF: begin
                nxt_prdata[IRQ_W-1:0] = irq_mask_ff;
            end
            SW_STS_OFF: begin
                nxt_prdata[BUSY_BIT]     = (state_ff != SW_IDLE);
                nxt_prdata[STAB_RUN_BIT] = stab_run_ff;
            end
            default: begin
                nxt_pslverr = 1'b1;
            end
        endcase
    end

    // APB answer: ready in the first access cycle, no wait states
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_ff <= psel && !penable && !pready_ff;
            if (psel && !penable) begin
                prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr_ff <= nxt_pslverr;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Fast RC postscaler and previous levels for falling edge detection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            psc_ff      <= '0;
            hf_prev_ff  <= 1'b0;
            old_prev_ff <= 1'b0;
            new_prev_ff <= 1'b0;
        end else if (clk_en) begin
            hf_prev_ff  <= osc_in.hf_rc;
            old_prev_ff <= old_lvl;
            new_prev_ff <= new_lvl;
            if (hf_prev_ff && !osc_in.hf_rc) begin
                psc_ff <= psc_ff + PSC_W'(1);
            end
        end
    end

    // Switch sequencer; a request changed mid-switch is taken after it ends
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff    <= SW_IDLE;
            act_ff      <= '{src: SRC_RST, freq: FREQ_RST};
            tgt_ff      <= '{src: SRC_RST, freq: FREQ_RST};
            edge_cnt_ff <= EDGE_ZERO;
            gate_low_ff <= 1'b0;
        end else if (clk_en) begin
            case (state_ff)
                SW_IDLE: begin
                    if (need_switch) begin
                        tgt_ff   <= nxt_tgt;
                        state_ff <= SW_GATE;
                    end
                end
                SW_GATE: begin
                    // Wait for the old clock to fall so its last high is whole
                    if (old_fall) begin
                        gate_low_ff <= 1'b1;
                        edge_cnt_ff <= EDGE_ZERO;
                        state_ff    <= SW_COUNT;
                    end
                end
                SW_COUNT: begin
                    if (sw_done) begin
                        act_ff      <= tgt_ff;
                        gate_low_ff <= 1'b0;
                        state_ff    <= SW_IDLE;
                    end else if (new_fall) begin
                        edge_cnt_ff <= edge_cnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff    <= SW_IDLE;
                    gate_low_ff <= 1'b0;
                end
            endcase
        end
    end

    // Clock output: held low while gated, swapped only at a low level
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clock_output_ff <= 1'b0;
        end else if (clk_en) begin
            clock_output_ff <= gate_low_ff ? 1'b0 : old_lvl;
        end
    end

    // Settle delay; the core keeps running on the new clock meanwhile
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_freq_stable_flag_ff <= 1'b1;
            stab_run_ff             <= 1'b0;
            stab_cnt_ff             <= '0;
        end else if (clk_en) begin
            if (sw_done && from_lf_up) begin
                int_freq_stable_flag_ff <= 1'b0;
                stab_run_ff             <= 1'b1;
                stab_cnt_ff             <= '0;
            end else if (stab_end) begin
                int_freq_stable_flag_ff <= 1'b1;
                stab_run_ff             <= 1'b0;
            end else if (stab_run_ff) begin
                stab_cnt_ff <= stab_cnt_ff + STAB_W'(1);
            end
            // Other switches leave the flag untouched
        end
    end

    // Timer crystal transition, phase hold and primary power
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_startup_status_ff         <= 1'b1;
            timer1_sysclk_running_flag_ff <= 1'b0;
            first_phase_hold_ff           <= 1'b0;
            primary_osc_enable_ff         <= 1'b1;
            secondary_run_mode_ff         <= 1'b0;
        end else if (clk_en) begin
            if ((state_ff == SW_IDLE) && need_switch) begin
                if (is_t1(nxt_tgt)) begin
                    osc_startup_status_ff <= 1'b0;
                    first_phase_hold_ff   <= 1'b1;
                end
                // Primary must run before it can be counted in
                if (nxt_tgt.src == SRC_PRIMARY) begin
                    primary_osc_enable_ff <= 1'b1;
                end
            end else if (sw_done) begin
                first_phase_hold_ff           <= 1'b0;
                timer1_sysclk_running_flag_ff <= is_t1(tgt_ff);
                secondary_run_mode_ff         <= is_t1(tgt_ff);
                primary_osc_enable_ff         <= !is_t1(tgt_ff);
                if (tgt_ff.src == SRC_PRIMARY) begin
                    osc_startup_status_ff <= 1'b1;
                end
            end
        end
    end

    // Sticky event bits; a set in the clearing cycle wins
    generate
        for (genvar i = 0; i < IRQ_W; i++) begin : g_sts
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    irq_sts_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    if (ev_vec[i]) begin
                        irq_sts_ff[i] <= 1'b1;
                    end else if (apb_wr && (paddr == IRQ_STS_OFF) && pwdata[i]) begin
                        irq_sts_ff[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Level interrupt from unmasked status
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= |(irq_sts_ff & irq_mask_ff);
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign clock_output       = clock_output_ff;
    assign first_phase_hold   = first_phase_hold_ff;
    assign primary_osc_enable = primary_osc_enable_ff;
    assign timer1_osc_enable  = timer1_osc_enable_ff;
    assign secondary_run_mode = secondary_run_mode_ff;
    assign irq                = irq_ff;

    // Checks; frozen cycles are not judged
    default clocking dflt_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    freq_write_any_a: assert property (
        apb_wr && (paddr == OSC_CTRL_OFF)
        |=> int_osc_freq_select_ff == $past(pwdata[FREQ_SEL_LSB +: 3]))
        else $error("frequency select write not taken");

    gated_low_a: assert property (
        (state_ff == SW_GATE) && old_fall |=> gate_low_ff ##1 !clock_output_ff)
        else $error("output not held low after old clock fell");

    eighth_edge_a: assert property (
        (state_ff == SW_COUNT) && new_fall && (edge_cnt_ff == EDGE_LAST)
        |=> (act_ff == $past(tgt_ff)) && !gate_low_ff && (state_ff == SW_IDLE))
        else $error("new clock not connected on eighth falling edge");

    settle_start_a: assert property (
        sw_done && from_lf_up |=> !int_freq_stable_flag_ff && stab_run_ff)
        else $error("settle delay not started leaving slow clock");

    stable_kept_a: assert property (
        sw_done && !is_lf(act_ff) && int_freq_stable_flag_ff && !stab_run_ff
        |=> int_freq_stable_flag_ff [*2])
        else $error("stable flag dropped after fast to fast switch");

    settle_end_a: assert property (
        stab_run_ff && (stab_cnt_ff == STAB_W'(STAB_CYCLES_P - 1)) && !sw_done
        |=> int_freq_stable_flag_ff && !stab_run_ff)
        else $error("stable flag not restored at end of delay");

    startup_clear_a: assert property (
        (state_ff == SW_IDLE) && need_switch && is_t1(nxt_tgt)
        |=> !osc_startup_status_ff && first_phase_hold_ff && (state_ff == SW_GATE))
        else $error("timer crystal switch did not clear startup status");

    phase_release_a: assert property (
        $fell(first_phase_hold_ff) |-> $past(sw_done))
        else $error("phase hold released before eighth edge");

    t1_flag_match_a: assert property (
        timer1_sysclk_running_flag_ff == is_t1(act_ff))
        else $error("timer running flag disagrees with active source");

    primary_down_a: assert property (
        secondary_run_mode_ff |-> !primary_osc_enable_ff && is_t1(act_ff))
        else $error("primary left powered in secondary run");

    resolve_off_a: assert property (
        apb_wr && (paddr == OSC_CTRL_OFF) && !timer1_osc_enable_ff
        |=> !sysclk_source_select_ff[SRC_T1_BIT] && (sysclk_source_select_ff[SRC_INT_BIT] ==
            $past(pwdata[SRC_SEL_LSB + SRC_INT_BIT])))
        else $error("disabled timer crystal request not resolved");

    no_glitch_a: assert property (
        gate_low_ff [*2] |-> !clock_output_ff)
        else $error("clock output pulsed during switch");

endmodule : ocs_top

// ---- dv/ocs_osc_model.sv ----
// Oscillator model for the clock source switcher's source side.
// Assumes one ref_clk domain; oscillator levels are free running counters.
`timescale 1ns/10ps
module ocs_osc_model (
    input  wire logic      ref_clk,
    input  wire logic      rst_n,
    input  wire logic      primary_osc_enable,
    input  wire logic      timer1_osc_enable,
    output ocs_pkg::ocs_osc_in_t osc_in
);
    import ocs_pkg::*;
    logic [7:0] cnt_ff;

    // Common divider; each source taps its own bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // Stopped oscillators sit low, so a stale level never fakes edges
    always_comb begin
        osc_in.hf_rc   = cnt_ff[1];
        osc_in.lf_rc   = cnt_ff[4];
        osc_in.t1_xtal = timer1_osc_enable & cnt_ff[3];
        osc_in.primary = primary_osc_enable & cnt_ff[2];
    end
endmodule : ocs_osc_model

// ---- dv/tb.sv ----
// Self-checking bench for the clock source switcher over APB.
// Assumes the oscillator model drives osc_in and one 100 MHz clock.
`timescale 1ns/10ps
module tb;
    import ocs_pkg::*;
    localparam int STAB = 50;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        clk_en  = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, clock_output, first_phase_hold;
    logic        primary_osc_enable, timer1_osc_enable, secondary_run_mode, irq;
    ocs_osc_in_t osc_in;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc       = 0;

    always #5 ref_clk = ~ref_clk;

    ocs_top #(.STAB_CYCLES_P(STAB)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
        .clock_output(clock_output), .first_phase_hold(first_phase_hold),
        .primary_osc_enable(primary_osc_enable), .timer1_osc_enable(timer1_osc_enable),
        .secondary_run_mode(secondary_run_mode), .irq(irq));
    ocs_osc_model u_osc (.ref_clk(ref_clk), .rst_n(rst_n),
        .primary_osc_enable(primary_osc_enable), .timer1_osc_enable(timer1_osc_enable),
        .osc_in(osc_in));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task end_of_test;
        $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // Hang guard: whole run needs under two thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // One APB transfer; held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask : rdm

    task wait_idle;
        do apb(1'b0, SW_STS_OFF, 32'h0000_0000); while (rd[BUSY_BIT] !== 1'b0);
    endtask : wait_idle

    task t_reset;
        rdm(OSC_CTRL_OFF, 32'hFFFF_FFFF, 32'h0000_000C);
        rdm(T1_CTRL_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
        rdm(IRQ_MASK_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        $display("Test reset done");
    endtask : t_reset

    // Timer crystal disabled: source requests resolve through the fixed table
    task t_resolve;
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0001);
        rdm(SW_STS_OFF, 32'h0000_0001, 32'h0000_0000);
        rdm(OSC_CTRL_OFF, 32'h0000_0003, 32'h0000_0000);
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0003);
        rdm(SW_STS_OFF, 32'h0000_0001, 32'h0000_0001);
        wait_idle();
        rdm(OSC_CTRL_OFF, 32'h0000_0003, 32'h0000_0002);
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0003);
        rdm(SW_STS_OFF, 32'h0000_0001, 32'h0000_0000);
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0001);
        wait_idle();
        rdm(OSC_CTRL_OFF, 32'h0000_0003, 32'h0000_0000);
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0002);
        wait_idle();
        $display("Test resolve done");
    endtask : t_resolve

    // Up from slow RC: flag drops during the settle count, then sets again
    task t_settle;
        int n;
        n = 0;
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0072);
        wait_idle();
        rdm(OSC_CTRL_OFF, 32'h0000_0074, 32'h0000_0070);
        rdm(SW_STS_OFF, 32'h0000_0002, 32'h0000_0002);
        // Software polls the stable flag before trusting the clock
        do begin
            apb(1'b0, OSC_CTRL_OFF, 32'h0000_0000);
            n++;
        end while (rd[STABLE_BIT] !== 1'b1);
        chk(n > STAB / 12, 1'b1);
        rdm(OSC_CTRL_OFF, 32'h0000_0004, 32'h0000_0004);
        rdm(IRQ_STS_OFF, 32'h0000_0002, 32'h0000_0002);
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0032);
        rdm(OSC_CTRL_OFF, 32'h0000_0004, 32'h0000_0004);
        // Slow postscaled target keeps the switch counting for hundreds of cycles
        repeat (8) @(posedge ref_clk);
        chk(clock_output, 1'b0);
        wait_idle();
        rdm(SW_STS_OFF, 32'h0000_0002, 32'h0000_0000);
        rdm(OSC_CTRL_OFF, 32'h0000_0004, 32'h0000_0004);
        $display("Test settle done");
    endtask : t_settle

    // Secondary run on the timer crystal
    task t_timer;
        int n;
        n = 0;
        apb(1'b1, T1_CTRL_OFF, 32'h0000_0001);
        repeat (40) @(posedge ref_clk);
        apb(1'b1, OSC_CTRL_OFF, 32'h0000_0031);
        repeat (2) @(posedge ref_clk);
        chk(first_phase_hold, 1'b1);
        rdm(OSC_CTRL_OFF, 32'h0000_0008, 32'h0000_0000);
        wait_idle();
        chk(secondary_run_mode, 1'b1);
        chk(primary_osc_enable, 1'b0);
        chk(first_phase_hold, 1'b0);
        chk(timer1_osc_enable, 1'b1);
        rdm(T1_CTRL_OFF, 32'hFFFF_FFFF, 32'h0000_0041);
        rdm(OSC_CTRL_OFF, 32'h0000_007F, 32'h0000_0035);
        // Crystal is high half of each 16-cycle period, so 64 samples give 32 highs
        repeat (64) begin
            @(posedge ref_clk);
            n += clock_output;
        end
        chk(n, 32);
        $display("Test timer done");
    endtask : t_timer

    // Masked, unmasked and cleared interrupt
    task t_irq;
        chk(irq, 1'b0);
        apb(1'b1, IRQ_MASK_OFF, 32'h0000_0004);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b1);
        apb(1'b1, IRQ_STS_OFF, 32'h0000_0007);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b0);
        rdm(IRQ_STS_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("Test irq done");
    endtask : t_irq

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_resolve();
        t_settle();
        t_timer();
        t_irq();
        end_of_test();
    end
endmodule : tb
